// ==== rtl/usb_buffer_descriptor_dma.sv ====
/*
 * Descriptor-driven data mover of a full/low-speed USB controller, with its
 * AXI4-Lite register slave, token and result ports toward the serial engine,
 * byte streams for transmit and receive, and a memory master port.
 * Assumes the serial engine sits on the same clock and software keeps the
 * ownership protocol on descriptors in memory.
 */
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module usb_buffer_descriptor_dma #(
   parameter int ENDPOINTS = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [31:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic tok_valid,
   output logic tok_ready,
   input wire logic [3:0] token_id,
   input wire logic [3:0] tok_endp,
   output logic tx_valid,
   input wire logic tx_ready,
   output logic [7:0] tx_data,
   output logic tx_last,
   input wire logic rx_valid,
   output logic rx_ready,
   input wire logic [7:0] rx_data,
   input wire logic rx_last,
   output logic res_valid,
   input wire logic res_ready,
   output logic [1:0] res_code,
   output logic [9:0] res_count,
   output logic res_toggle,
   output logic res_check,
   output logic res_odd,
   output logic mem_req,
   output logic mem_we,
   output logic [31:0] mem_addr,
   output logic [31:0] mem_wdata,
   output logic [3:0] mem_be,
   input wire logic mem_ack,
   input wire logic [31:0] mem_rdata
);
   typedef enum logic [3:0] {
      S_IDLE, S_RD0, S_RD1, S_CHECK, S_TXRD, S_TXSEND, S_RXWAIT, S_RXWR, S_WB, S_ANSWER
   } state_type;

   // ---------------------------------------------------------------------
   // Register slave
   // ---------------------------------------------------------------------
   logic [1:0] control;
   logic [22:0] table_base_page;
   logic [15:0] ep_enable;
   logic aw_held, w_held;
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic [31:0] byte_mask;
   logic do_write, bank_clear;
   logic wr_control, wr_page, wr_enable, wr_mapped;
   logic [7:0] rd_addr;
   logic rd_mapped;
   logic [31:0] rd_value, status_word;
   logic [1:0] last_code;
   logic [9:0] last_count;
   logic [ENDPOINTS*2-1:0] bank_bits;
   state_type state;

   assign awready = !aw_held;
   assign wready = !w_held;
   assign do_write = aw_held && w_held && !bvalid;
   assign byte_mask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
   assign wr_control = aw_addr_q == desc_pkg::REG_CONTROL;
   assign wr_page = aw_addr_q == desc_pkg::REG_TABLE_PAGE;
   assign wr_enable = aw_addr_q == desc_pkg::REG_EP_ENABLE;
   assign bank_clear = do_write && aw_addr_q == desc_pkg::REG_BANK;
   assign wr_mapped = wr_control || wr_page || wr_enable || aw_addr_q == desc_pkg::REG_STATUS
                      || aw_addr_q == desc_pkg::REG_BANK;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr_q <= '0;
         w_data_q <= '0;
         w_strb_q <= '0;
         bvalid <= 1'b0;
         bresp <= desc_pkg::RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            aw_held <= 1'b1;
            aw_addr_q <= {awaddr[7:2], 2'b00};
         end
         if (wvalid && wready) begin
            w_held <= 1'b1;
            w_data_q <= wdata;
            w_strb_q <= wstrb;
         end
         if (do_write) begin
            bvalid <= 1'b1;
            bresp <= wr_mapped ? desc_pkg::RESP_OKAY : desc_pkg::RESP_SLVERR;
            aw_held <= 1'b0;
            w_held <= 1'b0;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   logic [31:0] ctrl_merged, page_merged, enable_merged;
   assign ctrl_merged = ({30'h0, control} & ~byte_mask) | (w_data_q & byte_mask);
   assign page_merged = ({table_base_page, 9'h000} & ~byte_mask) | (w_data_q & byte_mask);
   assign enable_merged = ({16'h0000, ep_enable} & ~byte_mask) | (w_data_q & byte_mask);

   // Software picks the role; both roles run through the same engine below.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         control <= desc_pkg::CTRL_RESET; // [R07]
         table_base_page <= desc_pkg::PAGE_RESET;
         ep_enable <= desc_pkg::EP_ENABLE_RESET;
      end else if (do_write) begin
         if (wr_control) control <= ctrl_merged[1:0];
         if (wr_page) table_base_page <= page_merged[31:9];
         if (wr_enable) ep_enable <= enable_merged[15:0];
      end
   end

   assign rd_addr = {araddr[7:2], 2'b00};
   assign status_word = ({22'h0, last_count} << desc_pkg::STAT_COUNT_LSB)
                        | ({30'h0, last_code} << desc_pkg::STAT_CODE_LSB)
                        | ({31'h0, state != S_IDLE} << desc_pkg::STAT_BUSY_BIT);
   assign rd_mapped = rd_addr == desc_pkg::REG_CONTROL || rd_addr == desc_pkg::REG_TABLE_PAGE
                      || rd_addr == desc_pkg::REG_EP_ENABLE || rd_addr == desc_pkg::REG_STATUS
                      || rd_addr == desc_pkg::REG_BANK;
   assign rd_value = rd_addr == desc_pkg::REG_CONTROL ? {30'h0, control} :
                     rd_addr == desc_pkg::REG_TABLE_PAGE ? {table_base_page, 9'h000} :
                     rd_addr == desc_pkg::REG_EP_ENABLE ? {16'h0000, ep_enable} :
                     rd_addr == desc_pkg::REG_STATUS ? status_word :
                     rd_addr == desc_pkg::REG_BANK ? 32'(bank_bits) : 32'h0000_0000;
   assign arready = !rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= desc_pkg::RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rdata <= rd_value;
         rresp <= rd_mapped ? desc_pkg::RESP_OKAY : desc_pkg::RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end
   end

   // ---------------------------------------------------------------------
   // Descriptor engine
   // ---------------------------------------------------------------------
   mem_port_if mport ();
   logic [3:0] pid_q, endp_q;
   logic tx_q, issued, bank_toggle;
   logic [31:0] word0, pointer;
   logic [9:0] count, length;
   logic [7:0] byte_q;
   logic last_q;
   logic is_tx, ep_on, odd_now, own, keep, hold, halt;
   logic [31:0] desc_addr, buf_addr, next_word0;
   logic mem_state;
   logic [4:0] bank_sel;

   // Token direction per role: target receives OUT/SETUP, host receives IN.
   assign is_tx = control[desc_pkg::CTRL_HOST_BIT] ? (token_id != desc_pkg::PID_IN)
                                                   : (token_id == desc_pkg::PID_IN); // [R09]
   assign ep_on = control[desc_pkg::CTRL_ENABLE_BIT] && ep_enable[tok_endp];
   assign bank_sel = {endp_q, tx_q};
   assign odd_now = bank_bits[bank_sel]; // [R06] [R13]
   // Each direction spans 16 bytes: two 8-byte entries picked by the bank bit.
   assign desc_addr = ({table_base_page, 9'h000})
                      | ({28'h0, endp_q} << desc_pkg::ADDR_ENDP_LSB)
                      | ({31'h0, tx_q} << desc_pkg::ADDR_DIR_BIT)
                      | ({31'h0, odd_now} << desc_pkg::ADDR_ODD_BIT); // [R02] [R03] [R11] [R12]
   assign own = word0[desc_pkg::DESC_OWN_BIT];
   assign keep = word0[desc_pkg::DESC_KEEP_BIT]; // [R15]
   assign hold = word0[desc_pkg::DESC_HOLD_BIT]; // [R15]
   assign halt = word0[desc_pkg::DESC_HALT_BIT];
   assign length = word0[desc_pkg::DESC_COUNT_LSB +: desc_pkg::DESC_COUNT_W]; // [R14] [R15]
   assign buf_addr = pointer + (hold ? 32'h0 : {22'h0, count}); // [R16] [R20]
   // Word 0 on hand-back: receive count, owner cleared and token code unless kept.
   assign next_word0 = {word0[31:26], tx_q ? length : count, word0[15:8], keep, word0[6],
                        keep ? word0[5:2] : pid_q, 2'b00}; // [R14] [R17] [R18] [R19]
   assign mem_state = state == S_RD0 || state == S_RD1 || state == S_TXRD || state == S_RXWR
                      || state == S_WB;
   assign mport.start = mem_state && !issued;
   assign mport.we = state == S_RXWR || state == S_WB; // [R08]
   assign mport.addr = state == S_RD0 || state == S_WB ? desc_addr :
                       state == S_RD1 ? desc_addr + desc_pkg::DESC_POINTER_OFFSET : buf_addr;
   assign mport.wdata = state == S_WB ? next_word0 : {4{byte_q}};
   assign mport.be = state == S_RXWR ? (4'h1 << buf_addr[1:0]) : 4'hf;
   assign bank_toggle = state == S_WB && mport.done;
   assign tok_ready = state == S_IDLE;
   assign tx_valid = state == S_TXSEND;
   assign rx_ready = state == S_RXWAIT;
   assign res_valid = state == S_ANSWER;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         issued <= 1'b0;
      end else if (mport.done) begin
         issued <= 1'b0;
      end else if (mport.start) begin
         issued <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= S_IDLE;
         pid_q <= '0;
         endp_q <= '0;
         tx_q <= 1'b0;
         word0 <= '0;
         pointer <= '0;
         count <= '0;
         byte_q <= '0;
         last_q <= 1'b0;
         tx_data <= '0;
         tx_last <= 1'b0;
         res_code <= desc_pkg::RES_DONE;
         res_count <= '0;
         res_toggle <= 1'b0;
         res_check <= 1'b0;
         res_odd <= 1'b0;
         last_code <= desc_pkg::RES_DONE;
         last_count <= '0;
      end else begin
         case (state)
            S_IDLE: begin
               if (tok_valid) begin
                  pid_q <= token_id;
                  endp_q <= tok_endp;
                  tx_q <= is_tx;
                  count <= '0;
                  res_code <= desc_pkg::RES_IGNORED;
                  res_count <= '0;
                  state <= ep_on ? S_RD0 : S_ANSWER; // [R10]
               end
            end
            S_RD0: if (mport.done) begin
               word0 <= mport.rdata;
               state <= S_RD1;
            end
            S_RD1: if (mport.done) begin
               pointer <= mport.rdata; // [R16]
               state <= S_CHECK;
            end
            S_CHECK: begin
               res_toggle <= word0[desc_pkg::DESC_TOGGLE_BIT];
               res_check <= word0[desc_pkg::DESC_TCHECK_BIT];
               res_odd <= odd_now;
               if (!own) begin
                  res_code <= desc_pkg::RES_NAK; // [R04] [R22]
                  state <= S_ANSWER;
               end else if (halt) begin
                  res_code <= desc_pkg::RES_STALL;
                  state <= S_ANSWER;
               end else if (tx_q) begin
                  state <= length == 10'h000 ? S_WB : S_TXRD;
               end else begin
                  state <= S_RXWAIT;
               end
            end
            S_TXRD: if (mport.done) begin
               tx_data <= mport.rdata[{buf_addr[1:0], 3'b000} +: 8]; // [R08]
               tx_last <= count + 10'h001 == length;
               state <= S_TXSEND;
            end
            S_TXSEND: if (tx_ready) begin
               count <= count + 10'h001;
               state <= tx_last ? S_WB : S_TXRD;
            end
            S_RXWAIT: if (rx_valid) begin
               if (count < length) begin
                  byte_q <= rx_data;
                  last_q <= rx_last;
                  state <= S_RXWR;
               end else if (rx_last) begin
                  state <= S_WB;
               end
            end
            S_RXWR: if (mport.done) begin
               count <= count + 10'h001;
               state <= last_q ? S_WB : S_RXWAIT;
            end
            S_WB: if (mport.done) begin
               res_code <= desc_pkg::RES_DONE;
               res_count <= count;
               state <= S_ANSWER;
            end
            S_ANSWER: if (res_ready) begin
               last_code <= res_code;
               last_count <= res_count;
               state <= S_IDLE;
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   mem_master u_mem (
      .aclk(aclk),
      .aresetn(aresetn),
      .port(mport.responder),
      .mem_req(mem_req),
      .mem_we(mem_we),
      .mem_addr(mem_addr),
      .mem_wdata(mem_wdata),
      .mem_be(mem_be),
      .mem_ack(mem_ack),
      .mem_rdata(mem_rdata)
   );

   bank_select_bits #(.ENDPOINTS(ENDPOINTS)) u_bank (
      .aclk(aclk),
      .aresetn(aresetn),
      .clear_all(bank_clear),
      .toggle(bank_toggle),
      .select(bank_sel),
      .bits(bank_bits)
   );

   // ---------------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------------
   addr_build_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R11] [R12]
      state == S_RD0 && mport.start |-> mport.addr[31:9] == table_base_page
      && mport.addr[8:5] == endp_q && mport.addr[4] == tx_q && mport.addr[3] == odd_now
      && mport.addr[2:0] == 3'b000) else $error("descriptor address malformed");
   dir_role_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R09]
      tok_valid && tok_ready && ep_on && token_id == desc_pkg::PID_IN
      |=> tx_q == !control[desc_pkg::CTRL_HOST_BIT]) else $error("direction wrong for role");
   nak_untouched_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R04] [R22]
      state == S_CHECK && !own |=> state == S_ANSWER && res_code == desc_pkg::RES_NAK
      && !mport.start) else $error("unowned descriptor not refused");
   owned_access_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R10]
      mport.start && (state == S_TXRD || state == S_RXWR) |-> own && !halt)
      else $error("buffer touched without ownership");
   handback_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R18]
      state == S_WB && mport.start |-> mport.wdata[7] == keep)
      else $error("owner flag written back wrong");
   rx_count_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R19] [R17]
      state == S_WB && mport.start && !tx_q |-> mport.wdata[25:16] == count
      && (keep || mport.wdata[5:2] == pid_q)) else $error("receive count or token not stored");
   hold_addr_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R20]
      mport.start && (state == S_TXRD || state == S_RXWR) && hold |-> mport.addr == pointer)
      else $error("address advanced while held");
   bank_toggle_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R23] [R06]
      bank_toggle && !bank_clear |=> bank_bits[bank_sel] != $past(odd_now))
      else $error("bank bit did not toggle");
   tx_length_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R15]
      tx_valid && tx_ready && tx_last |-> count + 10'h001 == length)
      else $error("transmit length mismatch");
endmodule : usb_buffer_descriptor_dma

// ==== rtl/usb_bd_pkg.sv ====
/*
 * Shared constants of the buffer descriptor mover: register offsets and fields,
 * descriptor layout, descriptor address layout, token codes and result codes.
 * Assumes a 32-bit AXI4-Lite register bus and a 32-bit system memory port.
 */
//
// Overview of operation
// (R01) Software aligns the descriptor table to 512 bytes; base page points at it.
// (R02) Every endpoint direction has an even and an odd 8-byte descriptor.
// (R03) Each endpoint direction takes 16 bytes; 16 endpoints fill 512 bytes.
// (R04) Owner flag 0: processor owns descriptor and buffer; mover leaves them alone.
// (R05) Owner flag 1: processor must not touch descriptor or buffer.
// (R06) The mover alternates even and odd descriptors of each endpoint direction.
// (R07) Host and target roles, software selected, share data paths and descriptors.
// (R08) Receive moves bus data into memory; transmit moves memory data onto the bus.
// (R09) Target: OUT and SETUP receive, IN transmits; host: the reverse.
// (R10) A token on an enabled endpoint fetches its descriptor and checks ownership first.
// (R11) Descriptor address joins base page, endpoint, direction and bank bits.
// (R12) Direction bit of the descriptor address is 1 for transmit, 0 for receive.
// (R13) Bank bit is held inside, names the descriptor in use and toggles.
// (R14) Word 0 holds byte count 25:16, owner 7, toggle 6, flags 5:2, zeros 1:0.
// (R15) Mover reads keep, hold address, toggle check and length from the descriptor.
// (R16) Word 1 is a 32-bit pointer through which the buffer is reached.
// (R17) After a transfer the descriptor holds the token code and the amount moved; with keep set the code leaves bits 5:2 unchanged.
// (R18) On finishing a token the owner flag is cleared unless keep is set.
// (R19) At the end of a receive the byte count becomes the bytes received.
// (R20) With hold address set every buffer access uses the same address.
// (R21) Processor writes the owner byte last when it sets up a descriptor.
// (R22) A descriptor not held by the mover is answered with NAK, buffer untouched.
// (R23) One bank bit per endpoint direction toggles each time a descriptor completes.
package desc_pkg;
   // Register byte offsets.
   localparam logic [7:0] REG_CONTROL = 8'h00;
   localparam logic [7:0] REG_TABLE_PAGE = 8'h04;
   localparam logic [7:0] REG_EP_ENABLE = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0c;
   localparam logic [7:0] REG_BANK = 8'h10;
   // Control register fields and reset values.
   localparam int CTRL_HOST_BIT = 0;
   localparam int CTRL_ENABLE_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;
   localparam logic [15:0] EP_ENABLE_RESET = 16'h0000;
   localparam logic [22:0] PAGE_RESET = 23'h000000;
   // Status register fields.
   localparam int STAT_COUNT_LSB = 0;
   localparam int STAT_CODE_LSB = 12;
   localparam int STAT_BUSY_BIT = 16;
   // Descriptor word 0 fields and word 1 offset.
   localparam int DESC_COUNT_LSB = 16;
   localparam int DESC_COUNT_W = 10;
   localparam int DESC_OWN_BIT = 7;
   localparam int DESC_TOGGLE_BIT = 6;
   localparam int DESC_KEEP_BIT = 5;
   localparam int DESC_HOLD_BIT = 4;
   localparam int DESC_TCHECK_BIT = 3;
   localparam int DESC_HALT_BIT = 2;
   localparam int DESC_PID_LSB = 2;
   localparam logic [31:0] DESC_POINTER_OFFSET = 32'h0000_0004;
   // Descriptor address layout inside the table.
   localparam int ADDR_PAGE_LSB = 9;
   localparam int ADDR_ENDP_LSB = 5;
   localparam int ADDR_DIR_BIT = 4;
   localparam int ADDR_ODD_BIT = 3;
   // Token codes.
   localparam logic [3:0] PID_OUT = 4'h1;
   localparam logic [3:0] PID_IN = 4'h9;
   localparam logic [3:0] PID_SETUP = 4'hd;
   // Result codes.
   localparam logic [1:0] RES_DONE = 2'h0;
   localparam logic [1:0] RES_NAK = 2'h1;
   localparam logic [1:0] RES_STALL = 2'h2;
   localparam logic [1:0] RES_IGNORED = 2'h3;
   // AXI responses.
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : desc_pkg

// ==== rtl/mem_port_if.sv ====
/*
 * Internal carrier between the descriptor engine and its memory master.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface mem_port_if;
   logic start;
   logic we;
   logic [31:0] addr;
   logic [31:0] wdata;
   logic [3:0] be;
   logic done;
   logic [31:0] rdata;
   modport requester (output start, output we, output addr, output wdata, output be,
                      input done, input rdata);
   modport responder (input start, input we, input addr, input wdata, input be,
                      output done, output rdata);
endinterface : mem_port_if

// ==== rtl/bank_select_bits.sv ====
/*
 * One bank bit per endpoint direction, naming the even or odd descriptor in use.
 * Assumes toggle and clear come from logic on the same clock.
 */
`timescale 1ns/1ps
module bank_select_bits #(
   parameter int ENDPOINTS = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clear_all,
   input wire logic toggle,
   input wire logic [$clog2(ENDPOINTS*2)-1:0] select,
   output logic [ENDPOINTS*2-1:0] bits
);
   logic [ENDPOINTS*2-1:0] one_hot;
   assign one_hot = toggle ? ({{(ENDPOINTS*2-1){1'b0}}, 1'b1} << select) : '0;

   // A toggle in the same cycle as a clear survives the clear.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bits <= '0;
      end else if (clear_all) begin
         bits <= one_hot;
      end else begin
         bits <= bits ^ one_hot; // [R13] [R23]
      end
   end
endmodule : bank_select_bits

// ==== rtl/mem_master.sv ====
/*
 * Memory master: holds one request on the memory pins until it is acknowledged.
 * Assumes the memory answers every request with exactly one ack.
 */
`timescale 1ns/1ps
module mem_master (
   input wire logic aclk,
   input wire logic aresetn,
   mem_port_if.responder port,
   output logic mem_req,
   output logic mem_we,
   output logic [31:0] mem_addr,
   output logic [31:0] mem_wdata,
   output logic [3:0] mem_be,
   input wire logic mem_ack,
   input wire logic [31:0] mem_rdata
);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mem_req <= 1'b0;
         mem_we <= 1'b0;
         mem_addr <= '0;
         mem_wdata <= '0;
         mem_be <= '0;
         port.done <= 1'b0;
         port.rdata <= '0;
      end else begin
         port.done <= mem_req && mem_ack;
         if (mem_req && mem_ack) begin
            mem_req <= 1'b0;
            port.rdata <= mem_rdata;
         end else if (port.start) begin
            mem_req <= 1'b1;
            mem_we <= port.we;
            mem_addr <= port.addr;
            mem_wdata <= port.wdata;
            mem_be <= port.be;
         end
      end
   end
endmodule : mem_master

// ==== sim/mem_model.sv ====
/* Word memory behind the mover's memory port.
   Assumes one request at a time, held until ack. */
`timescale 1ns/1ps
module mem_model (
   input wire logic aclk,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   input wire logic [3:0] mem_be,
   output logic mem_ack,
   output logic [31:0] mem_rdata
);
   logic [31:0] ram [0:255];
   initial begin
      mem_ack = 1'b0;
      mem_rdata = 32'h0;
      foreach (ram[i]) ram[i] = 32'h0;
   end
   // Answers one cycle late; read data is scrambled outside the ack cycle.
   always @(posedge aclk) begin
      mem_ack <= mem_req && !mem_ack;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) begin
         mem_rdata <= ram[mem_addr[9:2]];
         for (int i = 0; i < 4; i++) if (mem_we && mem_be[i]) ram[mem_addr[9:2]][8*i+:8] <= mem_wdata[8*i+:8];
      end
   end
endmodule : mem_model

// ==== sim/tb_top.sv ====
/* Bench for the descriptor mover: AXI4-Lite set-up, tokens, memory checks.
   Assumes the memory model answers every request. */
`timescale 1ns/1ps
module tb_top;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
   logic rvalid, rready, tok_valid, tok_ready, tx_valid, tx_ready, tx_last, rx_valid, rx_ready;
   logic rx_last, res_valid, res_ready, res_toggle, res_check, res_odd, mem_req, mem_we, mem_ack;
   logic [31:0] awaddr, wdata, araddr, rdata, mem_addr, mem_wdata, mem_rdata;
   logic [3:0] wstrb, token_id, tok_endp, mem_be;
   logic [1:0] bresp, rresp, res_code;
   logic [9:0] res_count;
   logic [7:0] tx_data, rx_data;
   logic [8:0] txq[$];
   int error_cnt = 0, samples_checked = 0, cyc = 0;
   usb_buffer_descriptor_dma i_usb_buffer_descriptor_dma (.*);
   mem_model i_mem_model (.*);
   initial begin
      aclk = 0;
      forever #5 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      if (tx_valid === 1'b1) txq.push_back({tx_last, tx_data});
      if (++cyc > 5000) begin
         error_cnt++;
         close_out();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
      fork
         begin do @(posedge aclk); while (awready !== 1'b1); awvalid <= 0; end
         begin do @(posedge aclk); while (wready !== 1'b1); wvalid <= 0; end
         begin do @(posedge aclk); while (bvalid !== 1'b1); bready <= 0; chk(bresp, er); end
      join
   endtask : wr
   task automatic rd(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er);
      @(posedge aclk);
      {araddr, arvalid, rready} <= {a, 2'b11};
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rready <= 0;
      chk(rdata, exp);
      chk(rresp, er);
   endtask : rd
   task automatic tok(input logic [3:0] p, input logic [1:0] code, input int n, input int cnt);
      @(posedge aclk);
      {token_id, tok_endp, tok_valid} <= {p, 4'h1, 1'b1};
      do @(posedge aclk); while (tok_ready !== 1'b1);
      tok_valid <= 0;
      for (int i = 1; i <= n; i++) begin
         {rx_data, rx_last, rx_valid} <= {8'(i * 17), i == n, 1'b1};
         do @(posedge aclk); while (rx_ready !== 1'b1);
      end
      rx_valid <= 0;
      while (res_valid !== 1'b1) @(posedge aclk);
      chk(res_code, code);
      chk(res_count, cnt);
   endtask : tok
   task automatic close_out();
      $display("errors %0d checks %0d", error_cnt, samples_checked);
      if (error_cnt == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : close_out
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, tok_valid, rx_valid, rx_last} = 0;
      {awaddr, wdata, araddr, token_id, tok_endp, rx_data} = 0;
      {wstrb, tx_ready, res_ready} = 6'h3f;
      repeat (12) @(posedge aclk);
      aresetn <= 1;
      rd(32'h00, 32'h0, 2'h0);
      i_mem_model.ram[8'h8d] = 32'h00000100;
      i_mem_model.ram[8'h8c] = 32'h00020080;
      i_mem_model.ram[8'h40] = 32'h0000bbaa;
      i_mem_model.ram[8'h89] = 32'h00000140;
      i_mem_model.ram[8'h88] = 32'h000400c8;
      wr(32'h04, 32'h00000200, 2'h0);
      wr(32'h08, 32'h00000002, 2'h0);
      wr(32'h00, 32'h00000002, 2'h0);
      tok(desc_pkg::PID_IN, desc_pkg::RES_DONE, 0, 2);
      chk({txq[0], txq[1]}, 32'h000155bb);
      chk(txq.size(), 32'h2);
      chk(i_mem_model.ram[8'h8c], 32'h00020024);
      tok(desc_pkg::PID_IN, desc_pkg::RES_NAK, 0, 0);
      chk({res_toggle, res_check, res_odd}, 32'h1);
      chk(i_mem_model.ram[8'h8e], 32'h0);
      tok(desc_pkg::PID_OUT, desc_pkg::RES_DONE, 3, 3);
      chk({res_toggle, res_check, res_odd}, 32'h6);
      chk(i_mem_model.ram[8'h50], 32'h00332211);
      chk(i_mem_model.ram[8'h88], 32'h00030044);
      rd(32'h10, 32'h0000000c, 2'h0);
      rd(32'h40, 32'h0, desc_pkg::RESP_SLVERR);
      wr(32'h10, 32'h0, 2'h0);
      rd(32'h10, 32'h0, 2'h0);
      wr(32'h40, 32'h0, desc_pkg::RESP_SLVERR);
      aresetn <= 0;
      repeat (2) @(posedge aclk);
      aresetn <= 1;
      rd(32'h04, 32'h0, 2'h0);
      close_out();
   end
endmodule : tb_top
